// ### asxsc_pkg.sv
// asxsc_pkg: constants and types for the byte-strobe sram host controller.
// assumes one 100 MHz clock domain; the memory is asynchronous and clockless.
`default_nettype none
package asxsc_pkg;
  localparam int          DATA_W       = 32;
  localparam int          LANES        = 4;
  localparam int          ADDR_W       = 24;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SETUP_NS     = 10;
  localparam int          ACCESS_NS    = 25;
  localparam int          HOLD_NS      = 10;
  localparam logic [3:0]  SETUP_CYC    = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  ACCESS_CYC   = 4'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  HOLD_CYC     = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  LANES_IDLE   = 4'hF;
  localparam logic [31:0] DATA_RESET   = 32'h00000000;
  localparam logic        PROG_WIDTH_32 = 1'b0;
  typedef enum logic [3:0] {
    ASXSC_IDLE   = 4'b0001,
    ASXSC_SETUP  = 4'b0010,
    ASXSC_ACCESS = 4'b0100,
    ASXSC_HOLD   = 4'b1000
  } asxsc_state_t;
endpackage
`default_nettype wire

// ### asxsc_sync.sv
// asxsc_sync: two-flop synchroniser for a bus of pin inputs.
// assumes the inputs are asynchronous to clock_in.
`default_nettype none
module asxsc_sync #(
  parameter int W = 32
) (
  input  wire logic         clock_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } asxsc_sync_t;
  asxsc_sync_t st;
  asxsc_sync_t next_st;
  always_comb begin
    next_st.first  = async_in;
    next_st.second = st.first;
  end
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign sync_out = st.second;
endmodule
`default_nettype wire

// ### asxsc_host.sv
// asxsc_host: processor-side controller driving a 32-bit async sram through
// four byte strobes and one read/write line.
// assumes a user request port on clock_in; memory pins are resolved by the bench.
`default_nettype none
module asxsc_host
  import asxsc_pkg::*;
#(
  parameter logic [3:0] SETUP = asxsc_pkg::SETUP_CYC,
  parameter logic [3:0] ACCESS = asxsc_pkg::ACCESS_CYC,
  parameter logic [3:0] HOLD = asxsc_pkg::HOLD_CYC,
  parameter bit         STANDBY_ON_STROBE = 1'b1
) (
  input  wire logic                       clock_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       req_valid_in,
  input  wire logic                       req_write_in,
  input  wire logic [asxsc_pkg::ADDR_W-1:0] req_addr_in,
  input  wire logic [asxsc_pkg::DATA_W-1:0] req_wdata_in,
  input  wire logic [asxsc_pkg::LANES-1:0]  req_lanes_in,
  output logic                            req_ready_out,
  output logic                            rsp_valid_out,
  output logic [asxsc_pkg::DATA_W-1:0]    rsp_rdata_out,
  output logic [asxsc_pkg::ADDR_W-1:0]    mem_addr_out,
  output logic [asxsc_pkg::LANES-1:0]     lane_selects_n_out,
  output logic                            low_word_enable_n_out,
  output logic                            high_word_enable_n_out,
  output logic                            write_enable_n_out,
  output logic                            output_enable_n_out,
  output logic                            program_width_select_out,
  output logic [asxsc_pkg::DATA_W-1:0]    processor_data_lines_out,
  output logic                            processor_data_lines_oe_out,
  input  wire logic [asxsc_pkg::DATA_W-1:0] memory_data_lines_in
);
  import asxsc_pkg::*;

  typedef struct packed {
    asxsc_state_t          state;
    logic [3:0]            count;
    logic                  write;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [LANES-1:0]      strobes_n;
    logic                  rw;
    logic                  drive;
    logic                  ready;
    logic                  rsp_valid;
    logic [DATA_W-1:0]     rdata;
    logic                  low_en_n;
    logic                  high_en_n;
  } asxsc_host_t;

  asxsc_host_t st;
  asxsc_host_t next_st;
  logic [DATA_W-1:0] rd_sync;

  asxsc_sync #(.W(DATA_W)) u_rd_sync (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .async_in (memory_data_lines_in),
    .sync_out (rd_sync)
  );

  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    case (st.state)
      ASXSC_IDLE: begin
        next_st.ready = 1'b1;
        if (req_valid_in && st.ready) begin
          next_st.ready = 1'b0;
          next_st.write = req_write_in;
          next_st.addr  = req_addr_in;
          next_st.wdata = req_wdata_in;
          next_st.rw    = !req_write_in;
          next_st.drive = req_write_in;
          next_st.count = SETUP;
          next_st.strobes_n = ~req_lanes_in;
          next_st.state = ASXSC_SETUP;
        end
      end
      ASXSC_SETUP: begin
        // strobes held inactive during setup; addr and rw settle first
        next_st.strobes_n = st.strobes_n;
        if (st.count <= 4'h1) begin
          next_st.count = ACCESS;
          next_st.state = ASXSC_ACCESS;
        end else begin
          next_st.count = st.count - 4'h1;
        end
      end
      ASXSC_ACCESS: begin
        if (st.count <= 4'h1) begin
          next_st.count     = HOLD;
          next_st.strobes_n = LANES_IDLE;
          next_st.state     = ASXSC_HOLD;
          if (!st.write) begin
            next_st.rdata     = rd_sync;
            next_st.rsp_valid = 1'b1;
          end
        end else begin
          next_st.count = st.count - 4'h1;
        end
      end
      ASXSC_HOLD: begin
        if (st.count <= 4'h1) begin
          next_st.drive = 1'b0;
          next_st.rw    = 1'b1;
          next_st.ready = 1'b1;
          next_st.state = ASXSC_IDLE;
          if (st.write) begin
            next_st.rsp_valid = 1'b1;
          end
        end else begin
          next_st.count = st.count - 4'h1;
        end
      end
      default: begin
        next_st.state = ASXSC_IDLE;
      end
    endcase
    // word enable active while either lane of its half is strobed, or grounded
    // a single strobe per half would lose partial writes to the other lane
    if (STANDBY_ON_STROBE) begin
      next_st.low_en_n  = (next_st.state == ASXSC_ACCESS) ? &next_st.strobes_n[1:0]
                                                          : 1'b1;
      next_st.high_en_n = (next_st.state == ASXSC_ACCESS) ? &next_st.strobes_n[3:2]
                                                          : 1'b1;
    end else begin
      next_st.low_en_n  = 1'b0;
      next_st.high_en_n = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st           <= '0;
      st.state     <= ASXSC_IDLE;
      st.strobes_n <= LANES_IDLE;
      st.rw        <= 1'b1;
      st.low_en_n  <= 1'b1;
      st.high_en_n <= 1'b1;
      st.rdata     <= DATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // strobes only asserted in the access phase, one line per lane
  logic [LANES-1:0] lane_strobe_n;
  assign lane_strobe_n = st.strobes_n;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lane_selects_n_out <= LANES_IDLE;
    end else begin
      lane_selects_n_out <= (next_st.state == ASXSC_ACCESS) ? next_st.strobes_n
                                                            : LANES_IDLE;
    end
  end

  assign req_ready_out               = st.ready;
  assign rsp_valid_out               = st.rsp_valid;
  assign rsp_rdata_out               = st.rdata;
  assign mem_addr_out                = st.addr;
  assign low_word_enable_n_out       = st.low_en_n;
  assign high_word_enable_n_out      = st.high_en_n;
  assign write_enable_n_out          = st.rw;
  assign output_enable_n_out         = 1'b0;
  assign program_width_select_out    = PROG_WIDTH_32;
  assign processor_data_lines_out    = st.wdata;
  assign processor_data_lines_oe_out = st.drive;

  // host drives data only while write enable is low
  property p_drive_only_write;
    @(posedge clock_in) disable iff (!rst_b_in)
      processor_data_lines_oe_out |-> !write_enable_n_out;
  endproperty
  a_drive_only_write: assert property (p_drive_only_write) else $error("data driven on read");

  property p_oe_low;
    @(posedge clock_in) disable iff (!rst_b_in) output_enable_n_out == 1'b0;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("output enable not grounded");

  property p_width_low;
    @(posedge clock_in) disable iff (!rst_b_in) program_width_select_out == 1'b0;
  endproperty
  a_width_low: assert property (p_width_low) else $error("width select not low");

  property p_idle_strobes;
    @(posedge clock_in) disable iff (!rst_b_in)
      (st.state == ASXSC_IDLE) |-> (lane_selects_n_out == LANES_IDLE);
  endproperty
  a_idle_strobes: assert property (p_idle_strobes) else $error("strobe active when idle");

  property p_rw_matches;
    @(posedge clock_in) disable iff (!rst_b_in)
      (st.state == ASXSC_ACCESS) |-> (write_enable_n_out == !st.write);
  endproperty
  a_rw_matches: assert property (p_rw_matches) else $error("read/write wrong in access");

  property p_low_word;
    @(posedge clock_in) disable iff (!rst_b_in)
      STANDBY_ON_STROBE |-> (low_word_enable_n_out == &lane_selects_n_out[1:0]);
  endproperty
  a_low_word: assert property (p_low_word) else $error("low word enable mismatch");

  property p_high_word;
    @(posedge clock_in) disable iff (!rst_b_in)
      STANDBY_ON_STROBE |-> (high_word_enable_n_out == &lane_selects_n_out[3:2]);
  endproperty
  a_high_word: assert property (p_high_word) else $error("high word enable mismatch");

  sequence s_start;
    req_valid_in && req_ready_out;
  endsequence
  property p_access_time;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_start |-> ##[1:40] rsp_valid_out;
  endproperty
  a_access_time: assert property (p_access_time) else $error("no response in time");

  property p_busy;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_start |=> !req_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during access");

  property p_no_standby_grounded;
    @(posedge clock_in) disable iff (!rst_b_in)
      !STANDBY_ON_STROBE |=> (!low_word_enable_n_out && !high_word_enable_n_out);
  endproperty
  a_no_standby_grounded: assert property (p_no_standby_grounded) else $error("enables not low");
endmodule
`default_nettype wire

// ### asxsc_sram.sv
// asxsc_sram: behavioural x32 async sram with lane selects and word enables.
// assumes the host resolves nothing: rd_out is the bus level seen by the host.
`default_nettype none
module asxsc_sram
  import asxsc_pkg::*;
(
  input  wire logic [asxsc_pkg::ADDR_W-1:0] a_in,
  input  wire logic [asxsc_pkg::LANES-1:0]  sel_n_in,
  input  wire logic                         lo_en_n_in,
  input  wire logic                         hi_en_n_in,
  input  wire logic                         we_n_in,
  input  wire logic                         oe_n_in,
  input  wire logic [asxsc_pkg::DATA_W-1:0] wd_in,
  input  wire logic                         wd_oe_in,
  output logic      [asxsc_pkg::DATA_W-1:0] rd_out,
  output logic                              standby_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [0:255];
  logic [LANES-1:0]  lane_on;
  logic              flip = 1'b0;
  // floating lanes show a pattern that keeps moving
  always #7 flip = ~flip;
  always_comb begin
    for (int k = 0; k < LANES; k++) begin
      lane_on[k] = !sel_n_in[k] && !((k < 2) ? lo_en_n_in : hi_en_n_in);
    end
  end
  // standby follows the word enables only
  assign standby_out = lo_en_n_in && hi_en_n_in;
  always @* begin
    for (int k = 0; k < LANES; k++) begin
      if (lane_on[k] && !we_n_in)
        mem[a_in[7:0]][8*k +: 8] = wd_in[8*k +: 8];
    end
  end
  always_comb begin
    rd_out = mem[a_in[7:0]];
    for (int k = 0; k < LANES; k++) begin
      if (!(lane_on[k] && we_n_in && !oe_n_in))
        rd_out[8*k +: 8] = wd_oe_in ? wd_in[8*k +: 8] : {4{flip, ~flip}};
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
// testbench: self-checking bench for asxsc_host against asxsc_sram.
// assumes asxsc_pkg, asxsc_host and asxsc_sram are compiled first.
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((e) !== (g)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import asxsc_pkg::*;
  typedef struct packed {logic wr; logic [31:0] d;} asxsc_exp_t;
  logic              clock_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic              req_valid_in = 1'b0;
  logic              req_write_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = '0;
  logic [DATA_W-1:0] req_wdata_in = '0;
  logic [LANES-1:0]  req_lanes_in = '0;
  logic              req_ready_out, rsp_valid_out, low_word_enable_n_out;
  logic              high_word_enable_n_out, write_enable_n_out, output_enable_n_out;
  logic              program_width_select_out, processor_data_lines_oe_out, cur_wr = 1'b0;
  logic [DATA_W-1:0] rsp_rdata_out, processor_data_lines_out, memory_data_lines_in;
  logic [ADDR_W-1:0] mem_addr_out;
  logic [LANES-1:0]  lane_selects_n_out, cur_ln = '0;
  logic              g_ready, g_rsp_valid, g_lo_n, g_hi_n, g_we_n, g_oe_n, g_pw, g_wd_oe;
  logic              standby, g_standby;
  logic [DATA_W-1:0] g_rdata, g_wd, g_md;
  logic [ADDR_W-1:0] g_addr;
  logic [LANES-1:0]  g_sel_n;
  logic [31:0]       seed = 32'h6, shadow [0:255];
  int                bad_count = 0, cmp_count = 0;
  asxsc_exp_t        exp_q[$], e;
  always #5 clock_in = ~clock_in;
  asxsc_host asxsc_host_inst (.clock_in, .rst_b_in, .req_valid_in, .req_write_in, .req_addr_in,
    .req_wdata_in, .req_lanes_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .mem_addr_out,
    .lane_selects_n_out, .low_word_enable_n_out, .high_word_enable_n_out, .write_enable_n_out,
    .output_enable_n_out, .program_width_select_out, .processor_data_lines_out,
    .processor_data_lines_oe_out, .memory_data_lines_in);
  asxsc_sram asxsc_sram_inst (.a_in(mem_addr_out), .sel_n_in(lane_selects_n_out),
    .lo_en_n_in(low_word_enable_n_out), .hi_en_n_in(high_word_enable_n_out),
    .we_n_in(write_enable_n_out), .oe_n_in(output_enable_n_out),
    .wd_in(processor_data_lines_out), .wd_oe_in(processor_data_lines_oe_out),
    .rd_out(memory_data_lines_in), .standby_out(standby));
  // second host with word enables grounded: out of standby from the first clock after reset
  asxsc_host #(.STANDBY_ON_STROBE(1'b0)) asxsc_host_gnd_inst (.clock_in, .rst_b_in,
    .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in, .req_lanes_in,
    .req_ready_out(g_ready), .rsp_valid_out(g_rsp_valid), .rsp_rdata_out(g_rdata),
    .mem_addr_out(g_addr), .lane_selects_n_out(g_sel_n), .low_word_enable_n_out(g_lo_n),
    .high_word_enable_n_out(g_hi_n), .write_enable_n_out(g_we_n),
    .output_enable_n_out(g_oe_n), .program_width_select_out(g_pw),
    .processor_data_lines_out(g_wd), .processor_data_lines_oe_out(g_wd_oe),
    .memory_data_lines_in(g_md));
  asxsc_sram asxsc_sram_gnd_inst (.a_in(g_addr), .sel_n_in(g_sel_n), .lo_en_n_in(g_lo_n),
    .hi_en_n_in(g_hi_n), .we_n_in(g_we_n), .oe_n_in(g_oe_n), .wd_in(g_wd),
    .wd_oe_in(g_wd_oe), .rd_out(g_md), .standby_out(g_standby));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [23:0] a, input logic [31:0] d,
                      input logic [3:0] ln);
    int n;
    n = 0;
    @(negedge clock_in);
    while (req_ready_out !== 1'b1 && n < 50) begin
      @(negedge clock_in);
      n++;
    end
    `CHK("ready", 1'b1, req_ready_out)
    exp_q.push_back('{wr, wr ? d : shadow[a[7:0]]});
    for (int k = 0; k < 4; k++) if (wr && ln[k]) shadow[a[7:0]][8*k +: 8] = d[8*k +: 8];
    cur_wr = wr;
    cur_ln = ln;
    req_valid_in = 1'b1;
    req_write_in = wr;
    req_addr_in = a;
    req_wdata_in = d;
    req_lanes_in = ln;
    @(negedge clock_in);
    req_valid_in = 1'b0;
    req_wdata_in = ~d;
  endtask
  // outputs are settled at the falling edge
  always @(negedge clock_in) begin
    if (rsp_valid_out === 1'b1) begin
      `CHK("answer expected", 1'b1, exp_q.size() != 0)
      `CHK("grounded answer", 1'b1, g_rsp_valid)
      e = exp_q.pop_front();
      if (!e.wr) begin
        `CHK("read data", e.d, rsp_rdata_out)
        `CHK("grounded read data", e.d, g_rdata)
      end
    end
    if (lane_selects_n_out !== 4'hF) begin
      `CHK("lane strobes", ~cur_ln, lane_selects_n_out)
      `CHK("write enable", ~cur_wr, write_enable_n_out)
      `CHK("low word enable", ~|cur_ln[1:0], low_word_enable_n_out)
      `CHK("high word enable", ~|cur_ln[3:2], high_word_enable_n_out)
      `CHK("grounded lane strobes", ~cur_ln, g_sel_n)
      `CHK("grounded word enables", 2'b00, {g_lo_n, g_hi_n})
      `CHK("grounded standby", 1'b0, g_standby)
      `CHK("grounded busy", 1'b0, g_ready)
      `CHK("data drive", cur_wr, processor_data_lines_oe_out)
    end
    `CHK("output enable", 1'b0, output_enable_n_out)
    `CHK("width select", 1'b0, program_width_select_out)
    `CHK("standby", &lane_selects_n_out, standby)
    `CHK("grounded ties", 2'b00, {g_oe_n, g_pw})
  end
  initial begin
    logic [23:0] a;
    repeat (6) @(negedge clock_in);
    `CHK("reset strobes", 4'hF, lane_selects_n_out)
    rst_b_in = 1'b1;
    // every lane mask, including none, over a full word
    for (int i = 0; i < 16; i++) begin
      a = 24'(rnd());
      xfer(1'b1, a, rnd(), 4'hF);
      xfer(1'b1, a, rnd(), 4'(i));
      xfer(1'b0, a, rnd(), 4'hF);
    end
    repeat (20) @(negedge clock_in);
    `CHK("pending answers", 0, exp_q.size())
    print_verdict();
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
